// ==== pkg/osa_pkg.sv ====
// Package of constants for the occupancy set point and alarm supervisor
package osa_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned SEC_IN_S = 1;
    localparam int unsigned CYC_PER_SEC = CLK_HZ * SEC_IN_S;
    localparam int unsigned ACT_DELAY_MAX_S = 300;
    localparam logic [31:0] ADDR_CTRL = 32'h00000000;
    localparam logic [31:0] ADDR_SP_HIGH = 32'h00000004;
    localparam logic [31:0] ADDR_SP_LOW = 32'h00000008;
    localparam logic [31:0] ADDR_ACT_DELAY = 32'h0000000C;
    localparam logic [31:0] ADDR_LOW_AIR_OCC = 32'h00000010;
    localparam logic [31:0] ADDR_WARN_OCC = 32'h00000014;
    localparam logic [31:0] ADDR_LOW_AIR_RED = 32'h00000018;
    localparam logic [31:0] ADDR_WARN_RED = 32'h0000001C;
    localparam logic [31:0] ADDR_TEMP_LO = 32'h00000020;
    localparam logic [31:0] ADDR_TEMP_HI = 32'h00000024;
    localparam logic [31:0] ADDR_TEMP_OFS = 32'h00000028;
    localparam logic [31:0] ADDR_RELAY_SEL = 32'h0000002C;
    localparam logic [31:0] ADDR_SASH_HEIGHT = 32'h00000030;
    localparam logic [31:0] ADDR_SASH_DELAY = 32'h00000034;
    localparam logic [31:0] ADDR_SASH_REPEAT = 32'h00000038;
    localparam logic [31:0] ADDR_MUTE = 32'h0000003C;
    localparam logic [31:0] ADDR_STATUS = 32'h00000040;
    localparam logic [31:0] ADDR_TEMP_DISP = 32'h00000044;
    localparam int CTRL_DUAL_EN = 0;
    localparam int CTRL_MANUAL = 1;
    localparam int CTRL_UNITS_F = 2;
    localparam int CTRL_SHOW_TEMP = 3;
    localparam int CTRL_SASH_SWITCH = 4;
    localparam int CTRL_REPEAT_EN = 5;
    localparam int CTRL_SASH_EN = 6;
    localparam int CTRL_W = 7;
    localparam logic [6:0] CTRL_RST = 7'h49;
    localparam logic [15:0] SP_HIGH_RST = 16'h01F4;
    localparam logic [15:0] SP_LOW_RST = 16'h012C;
    localparam logic [8:0] ACT_DELAY_RST = 9'h01E;
    localparam logic [8:0] ACT_DELAY_MAX = 9'h12C;
    localparam logic [15:0] LOW_AIR_OCC_RST = 16'h0190;
    localparam logic [15:0] WARN_OCC_RST = 16'h01C2;
    localparam logic [15:0] LOW_AIR_RED_RST = 16'h00F0;
    localparam logic [15:0] WARN_RED_RST = 16'h010E;
    localparam logic signed [15:0] TEMP_MIN = 16'sh0000;
    localparam logic signed [15:0] TEMP_MAX = 16'sh03E8;
    localparam logic signed [15:0] TEMP_LO_RST = 16'sh0032;
    localparam logic signed [15:0] TEMP_HI_RST = 16'sh0190;
    localparam logic signed [15:0] OFS_MIN = -16'sh0032;
    localparam logic signed [15:0] OFS_MAX = 16'sh0032;
    localparam logic signed [15:0] F_OFFSET = 16'sh0140;
    localparam logic [15:0] SASH_HEIGHT_RST = 16'h0064;
    localparam logic [15:0] SASH_DELAY_RST = 16'h003C;
    localparam logic [15:0] SASH_REPEAT_RST = 16'h012C;
    localparam logic [1:0] COND_HIGH = 2'h0;
    localparam logic [1:0] COND_LOW = 2'h1;
    localparam logic [1:0] COND_MANUAL = 2'h2;
    typedef enum logic [1:0] {OSA_OCC = 2'b00, OSA_WAIT = 2'b01, OSA_UNOCC = 2'b11} osa_occ_e;
    typedef enum logic [1:0] {OSA_IDLE = 2'b00, OSA_DELAY = 2'b01, OSA_SOUND = 2'b11, OSA_MUTED = 2'b10} osa_sash_e;
endpackage

// ==== verilog/osa_supervisor.sv ====
// Occupancy set point, temperature and close-sash alarm supervisor with APB registers
// Summary of operation
// [RULE1] Vacant presence starts a 0-300 s delay; low set point only after expiry.
// [RULE2] Presence returning during the delay cancels the change; high set point kept.
// [RULE3] Occupied airflow judged against occupied low-air and warning thresholds.
// [RULE4] Unoccupied airflow judged against separate reduced low-air and warning thresholds.
// [RULE5] Typical set points 0.50 and 0.30 m/s, alarms near 80% and 90%.
// [RULE6] Occupancy comes from the second input, a closed contact from the presence detector.
// [RULE7] Presence detector learns its background at power up.
// [RULE8] Presence detector relearns background periodically, absorbing stationary objects.
// [RULE9] Low temperature point settable 0.0 up to high point; low alarm flagged.
// [RULE10] High temperature point settable from low point to 100.0; high alarm flagged.
// [RULE11] Signed temperature offset added, limited to minus five to plus five degrees.
// [RULE12] Units setting presents temperature in Celsius or Fahrenheit.
// [RULE13] Show-temperature setting gates the display only, not measurement or alarms.
// [RULE14] Low temperature alarm drives its configured relay output.
// [RULE15] High temperature alarm drives its configured relay output.
// [RULE16] Close-sash alarm when sash open while the cupboard is unoccupied.
// [RULE17] Close-sash alarm waits a configurable delay after the condition arises.
// [RULE18] Optional repeat re-sounds the close-sash alarm at intervals while open.
// [RULE19] Sash-open sensing selectable between position sensor and micro switch.
// [RULE20] With dual set point active, condition shows high, low or manual.
// [RULE21] Close-sash alarm clears on occupancy or closed sash; muted alarm re-sounds.
// [RULE22] Temperature alarms use offset-corrected value: above high, below low.
// [RULE23] Occupancy return switches to occupied set point and thresholds immediately.
`timescale 1ns/1ps
module osa_supervisor #(
    parameter int unsigned CYC_PER_SEC = osa_pkg::CYC_PER_SEC,
    parameter int unsigned NUM_RELAYS = 3
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic PRESENCE_INPUT_SELECT,
    input wire logic [15:0] AIRFLOW,
    input wire logic signed [15:0] TEMP_RAW,
    input wire logic [15:0] SASH_POS,
    input wire logic SASH_SWITCH,
    output logic [15:0] SETPOINT,
    output logic [1:0] COND,
    output logic LOW_AIR_ALARM,
    output logic WARN_ALARM,
    output logic signed [15:0] TEMP_DISP,
    output logic TEMP_SHOW,
    output logic TEMP_LO_ALARM,
    output logic TEMP_HI_ALARM,
    output logic [NUM_RELAYS-1:0] RELAY,
    output logic SASH_ALARM
);
    // Relay select fields are two bits wide, so at most three relays can be addressed
    if (CYC_PER_SEC < 1 || NUM_RELAYS < 1 || NUM_RELAYS > 3) begin : g_param_check
        $error("osa_supervisor: unsupported parameter value");
    end

    function automatic logic signed [15:0] clamp_s(input logic signed [15:0] v,
            input logic signed [15:0] lo, input logic signed [15:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end else begin
            return v;
        end
    endfunction

    function automatic logic [NUM_RELAYS-1:0] relay_dec(input logic [1:0] sel, input logic on);
        logic [NUM_RELAYS-1:0] r;
        r = '0;
        for (int i = 0; i < NUM_RELAYS; i++) begin
            if (on && sel == 2'(i + 1)) begin
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    // Configuration registers
    logic [osa_pkg::CTRL_W-1:0] ctrl_r;
    logic [15:0] sp_high_r;
    logic [15:0] sp_low_r;
    logic [8:0] act_delay_r;
    logic [15:0] low_air_occ_r;
    logic [15:0] warn_occ_r;
    logic [15:0] low_air_red_r;
    logic [15:0] warn_red_r;
    logic signed [15:0] temp_lo_r;
    logic signed [15:0] temp_hi_r;
    logic signed [15:0] temp_ofs_r;
    logic [3:0] relay_sel_r;
    logic [15:0] sash_height_r;
    logic [15:0] sash_delay_r;
    logic [15:0] sash_repeat_r;

    // APB decode
    wire apb_setup = PSEL && !PENABLE;
    wire apb_wr = PSEL && PENABLE && PREADY && PWRITE;
    wire signed [15:0] wdata_s = PWDATA[15:0];
    wire hit_ctrl = PADDR == osa_pkg::ADDR_CTRL;
    wire hit_sp_high = PADDR == osa_pkg::ADDR_SP_HIGH;
    wire hit_sp_low = PADDR == osa_pkg::ADDR_SP_LOW;
    wire hit_act = PADDR == osa_pkg::ADDR_ACT_DELAY;
    wire hit_lao = PADDR == osa_pkg::ADDR_LOW_AIR_OCC;
    wire hit_wo = PADDR == osa_pkg::ADDR_WARN_OCC;
    wire hit_lar = PADDR == osa_pkg::ADDR_LOW_AIR_RED;
    wire hit_wr = PADDR == osa_pkg::ADDR_WARN_RED;
    wire hit_tlo = PADDR == osa_pkg::ADDR_TEMP_LO;
    wire hit_thi = PADDR == osa_pkg::ADDR_TEMP_HI;
    wire hit_ofs = PADDR == osa_pkg::ADDR_TEMP_OFS;
    wire hit_rel = PADDR == osa_pkg::ADDR_RELAY_SEL;
    wire hit_sh = PADDR == osa_pkg::ADDR_SASH_HEIGHT;
    wire hit_sd = PADDR == osa_pkg::ADDR_SASH_DELAY;
    wire hit_sr = PADDR == osa_pkg::ADDR_SASH_REPEAT;
    wire hit_mute = PADDR == osa_pkg::ADDR_MUTE;
    wire hit_stat = PADDR == osa_pkg::ADDR_STATUS;
    wire hit_tdisp = PADDR == osa_pkg::ADDR_TEMP_DISP;
    wire hit_any = hit_ctrl | hit_sp_high | hit_sp_low | hit_act | hit_lao | hit_wo | hit_lar | hit_wr
        | hit_tlo | hit_thi | hit_ofs | hit_rel | hit_sh | hit_sd | hit_sr | hit_mute | hit_stat | hit_tdisp;
    // Write clamps keep low point at or below high point, so the pair can never cross
    wire signed [15:0] tlo_wr = clamp_s(wdata_s, osa_pkg::TEMP_MIN, temp_hi_r); // [RULE9]
    wire signed [15:0] thi_wr = clamp_s(wdata_s, temp_lo_r, osa_pkg::TEMP_MAX); // [RULE10]
    wire signed [15:0] ofs_wr = clamp_s(wdata_s, osa_pkg::OFS_MIN, osa_pkg::OFS_MAX); // [RULE11]
    wire [8:0] act_wr = (PWDATA[15:0] > 16'(osa_pkg::ACT_DELAY_MAX)) ? osa_pkg::ACT_DELAY_MAX
        : PWDATA[8:0]; // [RULE1]
    wire mute_req = apb_wr && hit_mute && PWDATA[0];

    // One-second enable
    logic [31:0] div_r;
    logic sec_tick_r;
    wire div_end = div_r == 32'(CYC_PER_SEC - 1);

    // Occupancy
    osa_pkg::osa_occ_e occ_r;
    osa_pkg::osa_occ_e occ_nxt;
    logic [8:0] act_cnt_r;
    wire occupied_in = PRESENCE_INPUT_SELECT; // [RULE6]
    wire dual_on = ctrl_r[osa_pkg::CTRL_DUAL_EN];
    wire manual_on = ctrl_r[osa_pkg::CTRL_MANUAL];
    wire act_done = act_cnt_r >= act_delay_r;
    always_comb begin
        occ_nxt = occ_r;
        case (occ_r)
            osa_pkg::OSA_OCC: begin
                if (!occupied_in) begin
                    occ_nxt = osa_pkg::OSA_WAIT; // [RULE1]
                end
            end
            osa_pkg::OSA_WAIT: begin
                if (occupied_in) begin
                    occ_nxt = osa_pkg::OSA_OCC; // [RULE2]
                end else if (act_done) begin
                    occ_nxt = osa_pkg::OSA_UNOCC; // [RULE1]
                end
            end
            osa_pkg::OSA_UNOCC: begin
                if (occupied_in) begin
                    occ_nxt = osa_pkg::OSA_OCC; // [RULE23]
                end
            end
            default: occ_nxt = osa_pkg::OSA_OCC;
        endcase
    end
    // Manual or dual off keeps the occupied set regardless of presence
    wire use_low = dual_on && !manual_on && occ_r == osa_pkg::OSA_UNOCC;
    wire [15:0] sp_sel = use_low ? sp_low_r : sp_high_r;
    wire [15:0] low_thr = use_low ? low_air_red_r : low_air_occ_r; // [RULE3] [RULE4]
    wire [15:0] warn_thr = use_low ? warn_red_r : warn_occ_r; // [RULE3] [RULE4]
    wire [1:0] cond_sel = manual_on ? osa_pkg::COND_MANUAL : use_low ? osa_pkg::COND_LOW
        : osa_pkg::COND_HIGH; // [RULE20]

    // Temperature path, all in tenths of a degree
    wire signed [16:0] tcorr_w = 17'(TEMP_RAW) + 17'(temp_ofs_r); // [RULE11]
    wire signed [15:0] tcorr = clamp_s(tcorr_w[16] == tcorr_w[15] ? tcorr_w[15:0]
        : (tcorr_w[16] ? 16'sh8000 : 16'sh7FFF), 16'sh8000, 16'sh7FFF);
    wire signed [31:0] tf_w = (32'(tcorr) * 32'sd9) / 32'sd5 + 32'(osa_pkg::F_OFFSET);
    wire signed [15:0] tdisp_sel = ctrl_r[osa_pkg::CTRL_UNITS_F] ? tf_w[15:0] : tcorr; // [RULE12]
    wire t_hi = tcorr > temp_hi_r; // [RULE22]
    wire t_lo = tcorr < temp_lo_r; // [RULE22]

    // Close-sash alarm
    osa_pkg::osa_sash_e sash_r;
    osa_pkg::osa_sash_e sash_nxt;
    logic [15:0] sash_cnt_r;
    wire sash_open = ctrl_r[osa_pkg::CTRL_SASH_SWITCH] ? SASH_SWITCH
        : SASH_POS > sash_height_r; // [RULE19]
    wire sash_cond = ctrl_r[osa_pkg::CTRL_SASH_EN] && sash_open && !occupied_in; // [RULE16]
    wire repeat_on = ctrl_r[osa_pkg::CTRL_REPEAT_EN];
    always_comb begin
        sash_nxt = sash_r;
        case (sash_r)
            osa_pkg::OSA_IDLE: begin
                if (sash_cond) begin
                    sash_nxt = osa_pkg::OSA_DELAY;
                end
            end
            osa_pkg::OSA_DELAY: begin
                if (!sash_cond) begin
                    sash_nxt = osa_pkg::OSA_IDLE; // [RULE21]
                end else if (sash_cnt_r >= sash_delay_r) begin
                    sash_nxt = osa_pkg::OSA_SOUND; // [RULE17]
                end
            end
            osa_pkg::OSA_SOUND: begin
                if (!sash_cond) begin
                    sash_nxt = osa_pkg::OSA_IDLE; // [RULE21]
                end else if (mute_req) begin
                    sash_nxt = osa_pkg::OSA_MUTED;
                end
            end
            osa_pkg::OSA_MUTED: begin
                if (!sash_cond) begin
                    sash_nxt = osa_pkg::OSA_IDLE; // [RULE21]
                end else if (repeat_on && sash_cnt_r >= sash_repeat_r) begin
                    sash_nxt = osa_pkg::OSA_SOUND; // [RULE18]
                end
            end
            default: sash_nxt = osa_pkg::OSA_IDLE;
        endcase
    end
    wire sash_restart = sash_nxt != sash_r;

    // Read mux
    wire [31:0] status_w = {23'h0, sash_r == osa_pkg::OSA_MUTED, sash_r == osa_pkg::OSA_SOUND,
        t_hi, t_lo, AIRFLOW < warn_thr, AIRFLOW < low_thr, cond_sel, occ_r != osa_pkg::OSA_UNOCC};
    wire [31:0] rdata_sel =
        hit_ctrl ? 32'(ctrl_r) :
        hit_sp_high ? 32'(sp_high_r) :
        hit_sp_low ? 32'(sp_low_r) :
        hit_act ? 32'(act_delay_r) :
        hit_lao ? 32'(low_air_occ_r) :
        hit_wo ? 32'(warn_occ_r) :
        hit_lar ? 32'(low_air_red_r) :
        hit_wr ? 32'(warn_red_r) :
        hit_tlo ? {16'h0, temp_lo_r} :
        hit_thi ? {16'h0, temp_hi_r} :
        hit_ofs ? {16'h0, temp_ofs_r} :
        hit_rel ? 32'(relay_sel_r) :
        hit_sh ? 32'(sash_height_r) :
        hit_sd ? 32'(sash_delay_r) :
        hit_sr ? 32'(sash_repeat_r) :
        hit_stat ? status_w :
        hit_tdisp ? {16'h0, tdisp_sel} : 32'h00000000;

    // APB answer: one wait-free access phase, answer registered at setup
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end else begin
            PREADY <= apb_setup;
            PSLVERR <= apb_setup && !hit_any;
            PRDATA <= (apb_setup && !PWRITE) ? rdata_sel : 32'h00000000;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_r <= osa_pkg::CTRL_RST;
            sp_high_r <= osa_pkg::SP_HIGH_RST;
            sp_low_r <= osa_pkg::SP_LOW_RST;
            act_delay_r <= osa_pkg::ACT_DELAY_RST;
            low_air_occ_r <= osa_pkg::LOW_AIR_OCC_RST;
            warn_occ_r <= osa_pkg::WARN_OCC_RST;
            low_air_red_r <= osa_pkg::LOW_AIR_RED_RST;
            warn_red_r <= osa_pkg::WARN_RED_RST;
            temp_lo_r <= osa_pkg::TEMP_LO_RST;
            temp_hi_r <= osa_pkg::TEMP_HI_RST;
            temp_ofs_r <= 16'sh0000;
            relay_sel_r <= 4'h0;
            sash_height_r <= osa_pkg::SASH_HEIGHT_RST;
            sash_delay_r <= osa_pkg::SASH_DELAY_RST;
            sash_repeat_r <= osa_pkg::SASH_REPEAT_RST;
        end else if (apb_wr) begin
            if (hit_ctrl) ctrl_r <= PWDATA[osa_pkg::CTRL_W-1:0];
            if (hit_sp_high) sp_high_r <= PWDATA[15:0];
            if (hit_sp_low) sp_low_r <= PWDATA[15:0];
            if (hit_act) act_delay_r <= act_wr;
            if (hit_lao) low_air_occ_r <= PWDATA[15:0];
            if (hit_wo) warn_occ_r <= PWDATA[15:0];
            if (hit_lar) low_air_red_r <= PWDATA[15:0];
            if (hit_wr) warn_red_r <= PWDATA[15:0];
            if (hit_tlo) temp_lo_r <= tlo_wr;
            if (hit_thi) temp_hi_r <= thi_wr;
            if (hit_ofs) temp_ofs_r <= ofs_wr;
            if (hit_rel) relay_sel_r <= PWDATA[3:0];
            if (hit_sh) sash_height_r <= PWDATA[15:0];
            if (hit_sd) sash_delay_r <= PWDATA[15:0];
            if (hit_sr) sash_repeat_r <= PWDATA[15:0];
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            div_r <= 32'h00000000;
            sec_tick_r <= 1'b0;
        end else begin
            div_r <= div_end ? 32'h00000000 : div_r + 32'h00000001;
            sec_tick_r <= div_end;
        end
    end

    // Delay counters saturate so a long wait cannot wrap back below the limit
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            occ_r <= osa_pkg::OSA_OCC;
            act_cnt_r <= 9'h000;
        end else begin
            occ_r <= occ_nxt;
            if (occ_r != osa_pkg::OSA_WAIT) begin
                act_cnt_r <= 9'h000; // [RULE2]
            end else if (sec_tick_r && act_cnt_r != 9'h1FF) begin
                act_cnt_r <= act_cnt_r + 9'h001; // [RULE1]
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sash_r <= osa_pkg::OSA_IDLE;
            sash_cnt_r <= 16'h0000;
        end else begin
            sash_r <= sash_nxt;
            if (sash_restart) begin
                sash_cnt_r <= 16'h0000;
            end else if (sec_tick_r && sash_cnt_r != 16'hFFFF) begin
                sash_cnt_r <= sash_cnt_r + 16'h0001; // [RULE17] [RULE18]
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            SETPOINT <= osa_pkg::SP_HIGH_RST;
            COND <= osa_pkg::COND_HIGH;
            LOW_AIR_ALARM <= 1'b0;
            WARN_ALARM <= 1'b0;
            TEMP_DISP <= 16'sh0000;
            TEMP_SHOW <= 1'b0;
            TEMP_LO_ALARM <= 1'b0;
            TEMP_HI_ALARM <= 1'b0;
            RELAY <= '0;
            SASH_ALARM <= 1'b0;
        end else begin
            SETPOINT <= sp_sel; // [RULE1] [RULE23]
            COND <= cond_sel; // [RULE20]
            LOW_AIR_ALARM <= AIRFLOW < low_thr; // [RULE3] [RULE4]
            WARN_ALARM <= AIRFLOW < warn_thr; // [RULE3] [RULE4]
            TEMP_DISP <= tdisp_sel; // [RULE12]
            TEMP_SHOW <= ctrl_r[osa_pkg::CTRL_SHOW_TEMP]; // [RULE13]
            TEMP_LO_ALARM <= t_lo; // [RULE9]
            TEMP_HI_ALARM <= t_hi; // [RULE10]
            RELAY <= relay_dec(relay_sel_r[1:0], t_lo) | relay_dec(relay_sel_r[3:2], t_hi); // [RULE14] [RULE15]
            SASH_ALARM <= sash_nxt == osa_pkg::OSA_SOUND; // [RULE16]
        end
    end
endmodule // osa_supervisor

// ==== sim/osa_sup_assertions.sv ====
// Concurrent checks on the supervisor ports
`timescale 1ns/1ps
module osa_sup_assertions #(
    parameter int unsigned NUM_RELAYS = 3
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic PRESENCE_INPUT_SELECT,
    input wire logic [1:0] COND,
    input wire logic TEMP_LO_ALARM,
    input wire logic TEMP_HI_ALARM,
    input wire logic [NUM_RELAYS-1:0] RELAY,
    input wire logic SASH_ALARM
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence occ_back_s;
        PRESENCE_INPUT_SELECT [*3];
    endsequence
    apb_answer_a: assert property (PSEL && !PENABLE |=> PREADY) else $error("No answer after setup");
    apb_single_a: assert property (PREADY |=> !PREADY) else $error("Answer held too long");
    apb_err_a: assert property (PSLVERR |-> PREADY) else $error("Error flag without answer");
    read_zero_a: assert property (!(PREADY && !PWRITE) |-> PRDATA == 32'h00000000) else $error("Data outside read");
    occ_return_a: assert property (occ_back_s |-> COND != osa_pkg::COND_LOW) else $error("Low kept");
    // Low code shows two edges after the vacant sample that ended the wait
    low_after_vacant_a: assert property ($rose(COND == osa_pkg::COND_LOW) |->
        !$past(PRESENCE_INPUT_SELECT, 2) && !$past(PRESENCE_INPUT_SELECT, 3)) else $error("Low while occupied");
    cond_legal_a: assert property (COND != 2'h3) else $error("Illegal condition code");
    temp_excl_a: assert property (!(TEMP_LO_ALARM && TEMP_HI_ALARM)) else $error("Both alarms");
    sash_vacant_a: assert property (SASH_ALARM |-> !$past(PRESENCE_INPUT_SELECT)) else $error("Sash alarm");
    sash_clear_a: assert property (occ_back_s |-> !SASH_ALARM) else $error("Sash alarm kept");
    relay_cause_a: assert property (RELAY != '0 |-> TEMP_LO_ALARM || TEMP_HI_ALARM ||
        $past(TEMP_LO_ALARM) || $past(TEMP_HI_ALARM)) else $error("Relay without alarm");
endmodule // osa_sup_assertions
bind osa_supervisor osa_sup_assertions #(.NUM_RELAYS(NUM_RELAYS)) i_chk (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PRESENCE_INPUT_SELECT(PRESENCE_INPUT_SELECT), .COND(COND), .TEMP_LO_ALARM(TEMP_LO_ALARM),
    .TEMP_HI_ALARM(TEMP_HI_ALARM), .RELAY(RELAY), .SASH_ALARM(SASH_ALARM));

// ==== sim/osa_field_model.sv ====
// Field model: presence detector, temperature sensor and sash detectors
`timescale 1ns/1ps
module osa_field_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic occ_want,
    input wire logic signed [15:0] temp_want,
    input wire logic [15:0] sash_want,
    input wire logic sw_want,
    output logic presence,
    output logic signed [15:0] temp_raw,
    output logic [15:0] sash_pos,
    output logic sash_sw
);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            presence <= 1'b0;
            temp_raw <= 16'sh0000;
            sash_pos <= 16'h0000;
            sash_sw <= 1'b0;
        end else begin
            // Every wanted value is copied to its output one clock later; there is no motion or background logic
            presence <= occ_want;
            temp_raw <= temp_want;
            sash_pos <= sash_want;
            sash_sw <= sw_want;
        end
    end
endmodule // osa_field_model

// ==== sim/osa_supervisor_tb.sv ====
// Self-checking testbench for the supervisor
`timescale 1ns/1ps
module osa_supervisor_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h00000000;
    logic [31:0] pwdata = 32'h00000000;
    logic [15:0] airflow = 16'h01A4;
    logic occ_want = 1'b1;
    logic signed [15:0] temp_want = 16'sh00FA;
    logic [15:0] sash_want = 16'h0000;
    logic sw_want = 1'b0;
    logic [31:0] prdata, r;
    logic pready, pslverr, presence, sash_sw, temp_show, t_lo, t_hi, low_air, warn, sash_alarm, e;
    logic signed [15:0] temp_raw, temp_disp;
    logic [15:0] sash_pos, setpoint;
    logic [1:0] cond;
    logic [2:0] relay;
    int mismatches = 0;
    int checks_done = 0;
    int n;
    logic [31:0] ca [5] = '{osa_pkg::ADDR_ACT_DELAY, osa_pkg::ADDR_TEMP_HI, osa_pkg::ADDR_TEMP_LO,
        osa_pkg::ADDR_TEMP_OFS, osa_pkg::ADDR_TEMP_OFS};
    logic [31:0] cw [5] = '{32'h1FF, 32'h7D0, 32'h7D0, 32'hFF9C, 32'h64};
    logic [31:0] ce [5] = '{32'h12C, 32'h3E8, 32'h3E8, 32'hFFCE, 32'h32};
    initial begin
        forever #20 clk = ~clk;
    end
    osa_supervisor #(.CYC_PER_SEC(10), .NUM_RELAYS(3)) i_dut (.CLK(clk), .RESETN(resetn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PRESENCE_INPUT_SELECT(presence), .AIRFLOW(airflow), .TEMP_RAW(temp_raw),
        .SASH_POS(sash_pos), .SASH_SWITCH(sash_sw), .SETPOINT(setpoint), .COND(cond), .LOW_AIR_ALARM(low_air),
        .WARN_ALARM(warn), .TEMP_DISP(temp_disp), .TEMP_SHOW(temp_show), .TEMP_LO_ALARM(t_lo),
        .TEMP_HI_ALARM(t_hi), .RELAY(relay), .SASH_ALARM(sash_alarm));
    osa_field_model i_fld (.clk(clk), .resetn(resetn), .occ_want(occ_want), .temp_want(temp_want),
        .sash_want(sash_want), .sw_want(sw_want), .presence(presence), .temp_raw(temp_raw),
        .sash_pos(sash_pos), .sash_sw(sash_sw));
    task automatic give_verdict();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Holds the request until ready is sampled high at an edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int t;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            give_verdict();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, r, exp);
    endtask
    // Bounded wait; n keeps the cycles spent
    task automatic wt(input int sel, input logic [15:0] v);
        n = 0;
        while ((sel == 0 ? setpoint : {15'h0000, sash_alarm}) !== v && n < 80) begin
            cyc(1);
            n++;
        end
        if (n >= 80) begin
            mismatches++;
            give_verdict();
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        cyc(2);
        chk("setpoint", 32'(setpoint), 32'h1F4);
        rd("ctrl", osa_pkg::ADDR_CTRL, 32'h49);
        rd("sp low", osa_pkg::ADDR_SP_LOW, 32'h12C);
        rd("unmapped", 32'h80, 32'h0);
        chk("slverr", 32'(e), 32'h1);
        for (int i = 0; i < 5; i++) begin
            wr(ca[i], cw[i]);
            rd("clamp", ca[i], ce[i]);
        end
        wr(osa_pkg::ADDR_TEMP_LO, 32'h32);
        wr(osa_pkg::ADDR_TEMP_HI, 32'h190);
        wr(osa_pkg::ADDR_TEMP_OFS, 32'h0);
        wr(osa_pkg::ADDR_ACT_DELAY, 32'h3);
        chk("warn occ", 32'(warn), 32'h1);
        chk("low air occ", 32'(low_air), 32'h0);
        @(posedge clk);
        occ_want <= 1'b0;
        cyc(12);
        occ_want <= 1'b1;
        cyc(30);
        chk("sp kept", 32'(setpoint), 32'h1F4);
        @(posedge clk);
        occ_want <= 1'b0;
        airflow <= 16'h00FA;
        wt(0, 16'h012C);
        chk("act delay", 32'(n >= 18), 32'h1);
        chk("cond low", 32'(cond), 32'(osa_pkg::COND_LOW));
        chk("low air red", 32'(low_air), 32'h0);
        chk("warn red", 32'(warn), 32'h1);
        @(posedge clk);
        occ_want <= 1'b1;
        cyc(4);
        chk("sp back", 32'(setpoint), 32'h1F4);
        chk("low air back", 32'(low_air), 32'h1);
        wr(osa_pkg::ADDR_CTRL, 32'h4B);
        cyc(2);
        chk("cond manual", 32'(cond), 32'(osa_pkg::COND_MANUAL));
        wr(osa_pkg::ADDR_CTRL, 32'h49);
        wr(osa_pkg::ADDR_RELAY_SEL, 32'h9);
        temp_want <= 16'sh0195;
        cyc(3);
        chk("t hi", 32'(t_hi), 32'h1);
        chk("relay hi", 32'(relay), 32'h2);
        wr(osa_pkg::ADDR_TEMP_OFS, 32'hFFF6);
        cyc(3);
        chk("disp ofs", 32'(temp_disp), 32'h18B);
        chk("t hi ofs", 32'(t_hi), 32'h0);
        wr(osa_pkg::ADDR_CTRL, 32'h4D);
        cyc(3);
        chk("disp f", 32'(temp_disp), 32'h407);
        wr(osa_pkg::ADDR_CTRL, 32'h41);
        temp_want <= 16'sh0028;
        cyc(3);
        chk("show off", 32'(temp_show), 32'h0);
        chk("t lo", 32'(t_lo), 32'h1);
        chk("relay lo", 32'(relay), 32'h1);
        wr(osa_pkg::ADDR_SASH_DELAY, 32'h2);
        wr(osa_pkg::ADDR_SASH_REPEAT, 32'h3);
        wr(osa_pkg::ADDR_CTRL, 32'h69);
        sash_want <= 16'h00C8;
        occ_want <= 1'b0;
        wt(1, 16'h1);
        chk("sash delay", 32'(n >= 8), 32'h1);
        wr(osa_pkg::ADDR_MUTE, 32'h1);
        cyc(2);
        chk("muted", 32'(sash_alarm), 32'h0);
        wt(1, 16'h1);
        chk("repeat", 32'(n >= 18), 32'h1);
        @(posedge clk);
        sash_want <= 16'h0064;
        cyc(4);
        chk("closed", 32'(sash_alarm), 32'h0);
        wr(osa_pkg::ADDR_CTRL, 32'h79);
        sw_want <= 1'b1;
        wt(1, 16'h1);
        occ_want <= 1'b1;
        cyc(4);
        chk("occupied", 32'(sash_alarm), 32'h0);
        give_verdict();
    end
endmodule // osa_supervisor_tb
